/* dv/tb_buck_startup_sequencer.sv */
`timescale 1ns/100ps
`include "bss_defines.svh"
module tb_buck_startup_sequencer;
  // ********************************
  // signals and design under test
  // ********************************
  localparam int SENSE_N = 20; // short sensing phase keeps the run brief
  localparam int PRE_N = 40; // short preconditioning phase
  localparam int SS_N = 50; // short soft-start ramp
  logic sys_clk = 1'b0; // 50 MHz clock
  logic resetn = 1'b0; // reset, active low
  logic enable_in = 1'b0; // enable pin level
  logic reg_ready_in = 1'b0; // regulator good
  logic sense_hi_in = 1'b0; // upper band comparator
  logic sense_lo_in = 1'b0; // lower band comparator
  logic pwm_pulse_in = 1'b0; // pwm pulse
  logic pwm_hs_in = 1'b0; // pwm high-side command
  logic pwm_ls_in = 1'b0; // pwm low-side command
  logic internal_5v_supply_out, comp_force_400mv, comp_force_low, softstart_en;
  logic pwm_en, hs_gate, ls_gate, seq_done;
  bss_pkg::bss_thr_t thr_sel; // latched threshold
  int num_errors = 0; // mismatches seen
  int checks_done = 0; // comparisons made

  bss_seq #(.SENSE_CYC(SENSE_N), .PRECOND_CYC(PRE_N), .SS_CYC(SS_N)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .enable_in(enable_in), .reg_ready_in(reg_ready_in),
    .sense_hi_in(sense_hi_in), .sense_lo_in(sense_lo_in), .pwm_pulse_in(pwm_pulse_in),
    .pwm_hs_in(pwm_hs_in), .pwm_ls_in(pwm_ls_in), .internal_5v_supply_out(internal_5v_supply_out),
    .comp_force_400mv(comp_force_400mv), .comp_force_low(comp_force_low), .softstart_en(softstart_en),
    .pwm_en(pwm_en), .hs_gate(hs_gate), .ls_gate(ls_gate), .thr_sel(thr_sel), .seq_done(seq_done));

  // clock generator
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ********************************
  // reporting and compare tasks
  // ********************************
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail(string msg);
    num_errors++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask

  task automatic chk_bit(logic got, logic exp, string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk_cnt(int got, int exp, string msg);
    checks_done++;
    if (got != exp) fail(msg);
  endtask

  task automatic chk_thr(bss_pkg::bss_thr_t got, bss_pkg::bss_thr_t exp, string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask

  // phase output picked by index: 0 sense, 1 precondition, 2 soft-start
  function automatic logic phase_out(int k);
    case (k)
      0: return comp_force_400mv;
      1: return comp_force_low;
      default: return softstart_en;
    endcase
  endfunction

  // bounded wait for a phase to start, sampled at falling edges
  task automatic wait_phase(int k);
    int n;
    n = 0;
    while (phase_out(k) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 40) begin
        fail("phase never started");
        wrap_up();
      end
    end
  endtask

  // length of a phase in cycles; cap keeps a stuck output from hanging
  task automatic count_phase(int k, output int n);
    n = 0;
    while (phase_out(k) === 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 300) begin
      fail("phase never ended");
      wrap_up();
    end
  endtask

  // ********************************
  // scenarios
  // ********************************
  // full start-up from shutdown with a given comparator reading;
  // runs with the upper comparator low issue no pwm pulse, so the low side waits for the end of soft-start
  task automatic run_start(logic hi, logic lo, bss_pkg::bss_thr_t exp);
    int n;
    enable_in = 1'b0;
    reg_ready_in = 1'b1;
    pwm_ls_in = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk_bit(internal_5v_supply_out, 1'b0, "regulator on in shutdown");
    chk_bit(pwm_en | hs_gate | ls_gate, 1'b0, "switching in shutdown");
    enable_in = 1'b1;
    reg_ready_in = 1'b0;
    sense_hi_in = hi;
    sense_lo_in = lo;
    repeat (10) @(negedge sys_clk);
    chk_bit(internal_5v_supply_out, 1'b1, "regulator off while enabled");
    chk_bit(comp_force_400mv, 1'b0, "sensing before regulator ready");
    reg_ready_in = 1'b1;
    wait_phase(0);
    count_phase(0, n);
    chk_cnt(n, SENSE_N, "sensing length");
    chk_thr(thr_sel, exp, "threshold code");
    chk_bit(comp_force_low, 1'b1, "no precondition after sensing");
    count_phase(1, n);
    chk_cnt(n, PRE_N, "precondition length");
    chk_bit(softstart_en & pwm_en, 1'b1, "soft-start not engaged");
    pwm_ls_in = 1'b1;
    n = 0;
    while (softstart_en === 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
      if (n == 5) chk_bit(ls_gate, 1'b0, "low side before first pulse");
      if (n == 6) {pwm_hs_in, pwm_pulse_in} = {hi, hi};
      if (n == 7) chk_bit(hs_gate, hi, "high side wrong in soft-start");
      if (n == 7) {pwm_hs_in, pwm_pulse_in} = 2'h0;
      if (n == 9) chk_bit(ls_gate, hi, "low side wrong around first pulse");
    end
    if (n >= 300) begin
      fail("soft-start never ended");
      wrap_up();
    end
    chk_cnt(n, SS_N, "soft-start length");
    chk_bit(seq_done & ls_gate, 1'b1, "low side not running after soft-start");
    $display("start-up test done, threshold code %0d", exp);
  endtask

  // shutdown just after precondition starts aborts the sequence
  task automatic t_abort;
    enable_in = 1'b0;
    repeat (8) @(negedge sys_clk);
    enable_in = 1'b1;
    wait_phase(0);
    wait_phase(1);
    enable_in = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit(internal_5v_supply_out | comp_force_low, 1'b0, "abort not taken");
    $display("abort test done");
  endtask

  // main sequence; the last run shows a fresh sense after restart
  initial begin
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    run_start(1'b1, 1'b0, `BSS_THR_460MV);
    run_start(1'b0, 1'b0, `BSS_THR_320MV);
    run_start(1'b1, 1'b1, `BSS_THR_160MV);
    t_abort();
    run_start(1'b1, 1'b0, `BSS_THR_460MV);
    wrap_up();
  end
endmodule

/* logic/bss_in_sync.sv */
`timescale 1ns/100ps
// three-stage synchroniser; output changes once stages 1 and 2 agree
module bss_in_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic din, // asynchronous input
  output logic dout // filtered level
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] sh;
    logic out;
  } bss_sync_s;
  bss_sync_s st_ff;
  bss_sync_s nxt_st;

  // shift chain; stage 0 feeds only stage 1
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sh = {st_ff.sh[1:0], din};
    if (st_ff.sh[1] == st_ff.sh[2]) begin
      nxt_st.out = st_ff.sh[2];
    end
  end

  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= {{3{RST_VAL}}, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.out;
endmodule

/* logic/bss_seq.sv */
`timescale 1ns/100ps
`include "bss_defines.svh"
// Overview of operation
// - shutdown: regulator off, no switching
// - floating enable means enabled
// - start only after regulator is ready
// - 400 mV on comp for 2 ms
// - compare current, latch protection threshold
// - comp low for 4 ms afterwards
// - after 6 ms engage soft-start, switch
// - low side off until first pulse
// - after soft-start low side runs normally
// - threshold codes 460, 320, 160 mV
// - soft-start lasts 4.7 ms
module bss_seq #(
  parameter int SENSE_CYC = `BSS_SENSE_CYC, // sensing phase cycles
  parameter int PRECOND_CYC = `BSS_PRECOND_CYC, // preconditioning cycles
  parameter int SS_CYC = `BSS_SS_CYC // soft-start cycles
) (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic enable_in, // enable pin level, pulled high when floating
  input wire logic reg_ready_in, // internal 5 V regulator good
  input wire logic sense_hi_in, // comparator: current above 12k band limit
  input wire logic sense_lo_in, // comparator: current above 4k band limit
  input wire logic pwm_pulse_in, // pwm output pulse, same clock
  input wire logic pwm_hs_in, // pwm high-side command, same clock
  input wire logic pwm_ls_in, // pwm low-side command, same clock
  output logic internal_5v_supply_out, // regulator enable
  output logic comp_force_400mv, // drive 400 mV onto comp
  output logic comp_force_low, // pull comp low
  output logic softstart_en, // soft-start ramp running
  output logic pwm_en, // allow pwm to switch
  output logic hs_gate, // high-side gate drive
  output logic ls_gate, // low-side gate drive
  output logic [1:0] thr_sel, // latched protection threshold
  output logic seq_done // start-up complete
);
  // ****************************************
  // parameter checks
  // ****************************************
  // refused at elaboration outside 2 to 2**24 cycles; the 24-bit phase timer and its last-cycle compare serve 1 to 2**24 cycles
  if (SENSE_CYC < 2 || PRECOND_CYC < 2 || SS_CYC < 2 ||
      SENSE_CYC > 2**24 || PRECOND_CYC > 2**24 || SS_CYC > 2**24) begin
    $error("bss_seq: phase counts out of range");
  end

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sh_ff; // two-stage reset release
  logic rst_n; // synchronised reset
  logic en_s; // filtered enable
  logic rdy_s; // filtered regulator ready
  logic shi_s; // filtered comparator high
  logic slo_s; // filtered comparator low

  // reset release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sh_ff <= 2'h0;
    end else begin
      rst_sh_ff <= {rst_sh_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sh_ff[1];

  // enable resets high so a floating pin starts the part
  bss_in_sync #(.RST_VAL(1'b1)) u_en (.sys_clk(sys_clk), .rst_n(rst_n), .din(enable_in), .dout(en_s));
  bss_in_sync #(.RST_VAL(1'b0)) u_rdy (.sys_clk(sys_clk), .rst_n(rst_n), .din(reg_ready_in), .dout(rdy_s));
  bss_in_sync #(.RST_VAL(1'b0)) u_shi (.sys_clk(sys_clk), .rst_n(rst_n), .din(sense_hi_in), .dout(shi_s));
  bss_in_sync #(.RST_VAL(1'b0)) u_slo (.sys_clk(sys_clk), .rst_n(rst_n), .din(sense_lo_in), .dout(slo_s));

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    bss_pkg::bss_state_e state;
    logic [23:0] cnt; // phase timer
    logic first_pulse; // pwm has issued a pulse
    logic reg_on;
    logic c400;
    logic clow;
    logic ss;
    logic pwm;
    logic hs;
    logic ls;
    bss_pkg::bss_thr_t thr;
    logic done;
  } bss_seq_s;
  bss_seq_s st_ff;
  bss_seq_s nxt_st;

  // sequencer next state and registered outputs
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt = st_ff.cnt + 24'h1;
    case (st_ff.state)
      bss_pkg::BSS_SHUTDOWN: begin
        nxt_st.cnt = 24'h0;
        if (en_s) begin
          nxt_st.state = bss_pkg::BSS_WAIT_REG;
        end
      end
      bss_pkg::BSS_WAIT_REG: begin
        nxt_st.cnt = 24'h0;
        if (rdy_s) begin
          nxt_st.state = bss_pkg::BSS_SENSE;
        end
      end
      bss_pkg::BSS_SENSE: begin
        // latch on the last sensing cycle, after the node has settled
        if (st_ff.cnt == 24'(SENSE_CYC - 1)) begin
          if (shi_s && slo_s) begin
            nxt_st.thr = `BSS_THR_160MV;
          end else if (shi_s) begin
            nxt_st.thr = `BSS_THR_460MV;
          end else begin
            nxt_st.thr = `BSS_THR_320MV;
          end
          nxt_st.cnt = 24'h0;
          nxt_st.state = bss_pkg::BSS_PRECOND;
        end
      end
      bss_pkg::BSS_PRECOND: begin
        if (st_ff.cnt == 24'(PRECOND_CYC - 1)) begin
          nxt_st.cnt = 24'h0;
          nxt_st.first_pulse = 1'b0;
          nxt_st.state = bss_pkg::BSS_SOFTSTART;
        end
      end
      bss_pkg::BSS_SOFTSTART: begin
        if (pwm_pulse_in) begin
          nxt_st.first_pulse = 1'b1;
        end
        if (st_ff.cnt == 24'(SS_CYC - 1)) begin
          nxt_st.cnt = 24'h0;
          nxt_st.state = bss_pkg::BSS_RUN;
        end
      end
      bss_pkg::BSS_RUN: begin
        nxt_st.cnt = 24'h0;
      end
      default: begin
        nxt_st.state = bss_pkg::BSS_SHUTDOWN;
      end
    endcase
    // low enable aborts any phase
    if (!en_s) begin
      nxt_st.state = bss_pkg::BSS_SHUTDOWN;
      nxt_st.cnt = 24'h0;
      nxt_st.first_pulse = 1'b0;
    end
    // outputs decoded from next state so they leave flip-flops
    nxt_st.reg_on = (nxt_st.state != bss_pkg::BSS_SHUTDOWN);
    nxt_st.c400 = (nxt_st.state == bss_pkg::BSS_SENSE);
    nxt_st.clow = (nxt_st.state == bss_pkg::BSS_PRECOND);
    nxt_st.ss = (nxt_st.state == bss_pkg::BSS_SOFTSTART);
    nxt_st.pwm = nxt_st.ss || (nxt_st.state == bss_pkg::BSS_RUN);
    nxt_st.done = (nxt_st.state == bss_pkg::BSS_RUN);
    nxt_st.hs = nxt_st.pwm && pwm_hs_in;
    // low side held off during soft-start until the first pulse
    nxt_st.ls = nxt_st.pwm && pwm_ls_in && !pwm_hs_in &&
                (nxt_st.done || nxt_st.first_pulse);
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: bss_pkg::BSS_SHUTDOWN, cnt: 24'h0, thr: `BSS_THR_RST, default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign internal_5v_supply_out = st_ff.reg_on;
  assign comp_force_400mv = st_ff.c400;
  assign comp_force_low = st_ff.clow;
  assign softstart_en = st_ff.ss;
  assign pwm_en = st_ff.pwm;
  assign hs_gate = st_ff.hs;
  assign ls_gate = st_ff.ls;
  assign thr_sel = st_ff.thr;
  assign seq_done = st_ff.done;

  // ****************************************
  // checks
  // ****************************************
  property p_shutdown_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_ff.state == bss_pkg::BSS_SHUTDOWN) |-> !internal_5v_supply_out && !hs_gate && !ls_gate && !pwm_en;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("activity in shutdown");

  property p_wait_ready;
    @(posedge sys_clk) disable iff (!rst_n)
    (st_ff.state == bss_pkg::BSS_WAIT_REG && !rdy_s) |=> st_ff.state != bss_pkg::BSS_SENSE;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("sensing before regulator ready");

  property p_sense_len;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(comp_force_400mv) |-> comp_force_400mv && st_ff.cnt == 24'h0;
  endproperty
  a_sense_len: assert property (p_sense_len) else $error("sense phase not from zero");

  property p_sense_to_pre;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(comp_force_400mv) && en_s |-> comp_force_low;
  endproperty
  a_sense_to_pre: assert property (p_sense_to_pre) else $error("precondition not after sense");

  property p_ss_after_pre;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(softstart_en) |-> $past(comp_force_low) && !comp_force_low;
  endproperty
  a_ss_after_pre: assert property (p_ss_after_pre) else $error("soft-start without precondition");

  property p_ls_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    softstart_en && !st_ff.first_pulse |-> !ls_gate;
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("low side on before first pulse");

  property p_thr_stable;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_en && $past(pwm_en) |-> $stable(thr_sel);
  endproperty
  a_thr_stable: assert property (p_thr_stable) else $error("threshold changed in operation");

  property p_thr_code;
    @(posedge sys_clk) disable iff (!rst_n)
    thr_sel != 2'h3;
  endproperty
  a_thr_code: assert property (p_thr_code) else $error("illegal threshold code");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
    !en_s |=> st_ff.state == bss_pkg::BSS_SHUTDOWN;
  endproperty
  a_abort: assert property (p_abort) else $error("shutdown did not abort");

  property p_ls_run;
    @(posedge sys_clk) disable iff (!rst_n)
    seq_done && $past(seq_done) && $past(pwm_ls_in) && !$past(pwm_hs_in) && en_s |-> ls_gate;
  endproperty
  a_ls_run: assert property (p_ls_run) else $error("low side blocked after soft-start");
endmodule

/* shared/bss_defines.svh */
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH
// sensing phase length, microseconds
`define BSS_SENSE_TIME_US 2000
// preconditioning phase length, microseconds
`define BSS_PRECOND_TIME_US 4000
// soft-start ramp length, tenths of a millisecond
`define BSS_SS_TIME_TMS 47
// clock rate in MHz
`define BSS_CLK_MHZ 50
// cycle counts derived from the times above
`define BSS_SENSE_CYC (`BSS_SENSE_TIME_US * `BSS_CLK_MHZ)
`define BSS_PRECOND_CYC (`BSS_PRECOND_TIME_US * `BSS_CLK_MHZ)
`define BSS_SS_CYC (`BSS_SS_TIME_TMS * 100 * `BSS_CLK_MHZ)
// threshold selection codes: 160 mV, 320 mV, 460 mV
`define BSS_THR_160MV 2'h0
`define BSS_THR_320MV 2'h1
`define BSS_THR_460MV 2'h2
// reset value of the latched threshold
`define BSS_THR_RST 2'h1
`endif

/* shared/bss_pkg.sv */
package bss_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    BSS_SHUTDOWN = 3'b000,
    BSS_WAIT_REG = 3'b001,
    BSS_SENSE = 3'b010,
    BSS_PRECOND = 3'b011,
    BSS_SOFTSTART = 3'b100,
    BSS_RUN = 3'b101
  } bss_state_e;
  typedef logic [1:0] bss_thr_t;
endpackage
